// *** rtl/motion_program_jump_sequencer.v ***
// Purpose: program sequencer for waits, calls, blocks and jumps of one axis
// Assumes: move generator handshakes each type 3 command with START/DONE
// Notes:   subroutine entry table loaded with the program memory
`timescale 1ns/100ps
`include "seq_consts.vh"
// Notes on behaviour
// - wait stops motion and holds until chosen control bit of twelve is on
// - wait with bit already on continues right after preceding move ends
// - wait stops motion after continuous or positioning moves alike
// - ten programs and forty subroutines numbered 1 to 40 are held
// - multiaxis subroutines only from multiaxis code, single-axis likewise
// - both axes may run the same single-axis subroutine at once
// - call enters numbered subroutine; return resumes after the call
// - nesting allowed; an active subroutine may not be called again
// - current block number is shown on a status word
// - unconditional jump continues without forcing a stop
// - conditional jump goes to destination if bit on, else next command
// - jump testing starts when next type 3 command becomes active
// - control bit sampled every 2 ms while testing is active
// - testing ends on trigger or when a new block becomes active
// - a new block gets one final test before testing stops
// - of several jumps with no type 3 between, only last counts
// - jump from continuous move without stop only if distance suffices
// - stop first on positioning move, reverse, short move or non-move
// - jump stop uses jog acceleration and jog acceleration mode
// - active testing stops axis and ends before a call
// - active testing stops axis and ends before end of subroutine
module motion_program_jump_sequencer (
    input  wire                 CLK,
    input  wire                 RESETN,
    input  wire                 MULTIAXIS,
    input  wire                 RUN,
    input  wire [`ADDR_W-1:0]   START_ADDR,
    input  wire [`NUM_CTL-1:0]  CONTROL_INPUT_BIT,
    input  wire                 LOAD_WE,
    input  wire [`ADDR_W-1:0]   LOAD_ADDR,
    input  wire [`WORD_W-1:0]   LOAD_DATA,
    input  wire                 SUB_WE,
    input  wire [5:0]           SUB_NUM,
    input  wire [`ADDR_W-1:0]   SUB_ADDR,
    input  wire                 SUB_MULTI,
    input  wire [`DIST_W-1:0]   STOP_DIST,
    input  wire                 MOVE_DONE,
    output reg                  MOVE_START,
    output reg  [`OP_W-1:0]     MOVE_KIND,
    output reg  [`ARG_W-1:0]    MOVE_ARG,
    output reg                  JUMP_STOP,
    output reg                  JOG_ACCEL_SEL,
    output reg                  CONT_JUMP,
    output reg                  MOVE_ABORT,
    output reg  [15:0]          BLOCK_STATUS,
    output reg                  BUSY,
    output reg                  FAULT
);
    localparam S_IDLE  = 3'h0;
    localparam S_FETCH = 3'h1;
    localparam S_WAITM = 3'h2;
    localparam S_EXEC  = 3'h3;
    localparam S_MOVE  = 3'h4;
    localparam S_WAITB = 3'h5;
    localparam S_STOP  = 3'h6;
    localparam S_DONE  = 3'h7;

    wire [`NUM_CTL-1:0] ctl_s;
    wire [`WORD_W-1:0]  word;
    reg  [2:0]          st_r;
    reg  [`ADDR_W-1:0]  pc_r;
    reg  [`TEST_CNT_W-1:0] tick_cnt_r;
    reg                 tick_r;
    reg                 pend_r;
    reg                 testing_r;
    reg  [`CTL_W-1:0]   jctl_r;
    reg  [`ARG_W-1:0]   jdst_r;
    reg                 pos_move_r;
    reg                 dir_r;
    reg  [`ADDR_W-1:0]  after_stop_r;
    reg  [`ADDR_W-1:0]  stk_ret [0:`STACK_DEPTH-1];
    reg  [5:0]          stk_sub [0:`STACK_DEPTH-1];
    reg  [`STACK_PTR_W-1:0] sp_r;
    reg  [`ADDR_W-1:0]  sub_addr [1:`NUM_SUBS];
    reg  [`NUM_SUBS:1]  sub_multi;
    reg  [`NUM_SUBS:1]  sub_active_r;
    wire [`OP_W-1:0]    op  = word[`OP_LSB+`OP_W-1:`OP_LSB];
    wire [`ARG_W-1:0]   arg = word[`ARG_W-1:0];
    wire [`CTL_W-1:0]   wctl = word[`CTL_LSB+`CTL_W-1:`CTL_LSB];
    wire [5:0]          snum = arg[5:0];
    wire                is_t3 = (op == `OP_POSITIONING_MOVE) || (op == `OP_CONTINUOUS_MOVE) ||
                                (op == `OP_DWELL) || (op == `OP_WAIT) ||
                                (op == `OP_END);
    wire                bit_on = (jctl_r < `NUM_CTL) ? ctl_s[jctl_r] : 1'b0;
    wire                trig = testing_r && tick_r && bit_on;
    integer i;

    sync2 #(.W(`NUM_CTL)) u_sync (
        .clk   (CLK),
        .rst_n (RESETN),
        .d     (CONTROL_INPUT_BIT),
        .q     (ctl_s)
    );

    prog_mem u_mem (
        .clk   (CLK),
        .we    (LOAD_WE),
        .waddr (LOAD_ADDR),
        .wdata (LOAD_DATA),
        .raddr (pc_r),
        .rdata (word)
    );

    always @(posedge CLK) begin
        if (SUB_WE && SUB_NUM >= 6'h01 && SUB_NUM <= 6'h28) begin
            sub_addr[SUB_NUM]  <= SUB_ADDR;
            sub_multi[SUB_NUM] <= SUB_MULTI;
        end
    end

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tick_cnt_r <= {`TEST_CNT_W{1'b0}};
            tick_r     <= 1'b0;
        end else if (!testing_r) begin
            tick_cnt_r <= {`TEST_CNT_W{1'b0}};
            tick_r     <= 1'b1;
        end else if (tick_cnt_r == `TEST_CYCLES - 1) begin
            tick_cnt_r <= {`TEST_CNT_W{1'b0}};
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
            tick_r     <= 1'b0;
        end
    end

    // stack stays per sequencer, so each axis owns its own copy
    // per-axis state
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_r <= S_IDLE;
            pc_r <= {`ADDR_W{1'b0}};
            pend_r <= 1'b0;
            testing_r <= 1'b0;
            jctl_r <= {`CTL_W{1'b0}};
            jdst_r <= {`ARG_W{1'b0}};
            pos_move_r <= 1'b0;
            dir_r <= 1'b0;
            after_stop_r <= {`ADDR_W{1'b0}};
            sp_r <= {`STACK_PTR_W{1'b0}};
            sub_active_r <= {`NUM_SUBS{1'b0}};
            MOVE_START <= 1'b0;
            MOVE_KIND <= `OP_NULL;
            MOVE_ARG <= {`ARG_W{1'b0}};
            JUMP_STOP <= 1'b0;
            JOG_ACCEL_SEL <= 1'b0;
            CONT_JUMP <= 1'b0;
            MOVE_ABORT <= 1'b0;
            BLOCK_STATUS <= 16'h0000;
            BUSY <= 1'b0;
            FAULT <= 1'b0;
        end else begin
            MOVE_START <= 1'b0;
            MOVE_ABORT <= 1'b0;
            CONT_JUMP <= 1'b0;
            case (st_r)
            S_IDLE: begin
                BUSY <= 1'b0;
                if (RUN) begin
                    pc_r <= START_ADDR;
                    sp_r <= {`STACK_PTR_W{1'b0}};
                    sub_active_r <= {`NUM_SUBS{1'b0}};
                    pend_r <= 1'b0;
                    testing_r <= 1'b0;
                    FAULT <= 1'b0;
                    BUSY <= 1'b1;
                    st_r <= S_FETCH;
                end
            end
            S_FETCH: st_r <= S_WAITM;
            S_WAITM: st_r <= S_EXEC;
            S_EXEC: begin
                st_r <= S_FETCH;
                pc_r <= pc_r + 10'h001;
                if (is_t3) begin
                    // wait handed over as a stopping command
                    MOVE_KIND <= op;
                    MOVE_ARG <= arg;
                    MOVE_START <= 1'b1;
                    JUMP_STOP <= 1'b0;
                    JOG_ACCEL_SEL <= 1'b0;
                    pos_move_r <= (op == `OP_POSITIONING_MOVE);
                    dir_r <= arg[`DIR_BIT];
                    if (pend_r) begin
                        testing_r <= 1'b1;
                        pend_r <= 1'b0;
                    end
                    st_r <= (op == `OP_WAIT) ? S_WAITB : S_MOVE;
                end else if (op == `OP_BLOCK) begin
                    BLOCK_STATUS <= arg[15:0];
                    if (testing_r && bit_on) begin
                        pc_r <= jdst_r[`ADDR_W-1:0];
                    end
                    testing_r <= 1'b0;
                end else if (op == `OP_JUMP) begin
                    pc_r <= arg[`ADDR_W-1:0];
                end else if (op == `OP_CJUMP) begin
                    // tested later; a later jump replaces it
                    pend_r <= 1'b1;
                    jctl_r <= wctl;
                    jdst_r <= arg;
                end else if (op == `OP_CALL) begin
                    if (testing_r) begin
                        testing_r <= 1'b0;
                        MOVE_ABORT <= 1'b1;
                        JUMP_STOP <= 1'b1;
                        JOG_ACCEL_SEL <= 1'b1;
                    end
                    if (snum < 6'h01 || snum > 6'h28 ||
                        sub_multi[snum] != MULTIAXIS ||
                        sub_active_r[snum] || sp_r == `STACK_DEPTH) begin
                        FAULT <= 1'b1;
                        st_r <= S_DONE;
                    end else begin
                        stk_ret[sp_r[2:0]] <= pc_r + 10'h001;
                        stk_sub[sp_r[2:0]] <= snum;
                        sp_r <= sp_r + 4'h1;
                        sub_active_r[snum] <= 1'b1;
                        pc_r <= sub_addr[snum];
                    end
                end else if (op == `OP_ENDSUB) begin
                    if (testing_r) begin
                        testing_r <= 1'b0;
                        MOVE_ABORT <= 1'b1;
                        JUMP_STOP <= 1'b1;
                        JOG_ACCEL_SEL <= 1'b1;
                    end
                    if (sp_r == {`STACK_PTR_W{1'b0}}) begin
                        FAULT <= 1'b1;
                        st_r <= S_DONE;
                    end else begin
                        pc_r <= stk_ret[sp_r[2:0] - 3'h1];
                        sub_active_r[stk_sub[sp_r[2:0] - 3'h1]] <= 1'b0;
                        sp_r <= sp_r - 4'h1;
                    end
                end
                if (is_t3 && op == `OP_END) begin
                    st_r <= S_MOVE;
                end
            end
            S_WAITB: begin
                // bit already on moves on once preceding move ends
                if (MOVE_DONE) begin
                    st_r <= S_MOVE;
                end
            end
            S_MOVE: begin
                if (MOVE_KIND == `OP_WAIT || MOVE_KIND == `OP_NULL) begin
                    // wait: hold until bit on
                    if (MOVE_KIND == `OP_WAIT &&
                        (arg_bit(MOVE_ARG) || trig)) begin
                        st_r <= trig ? S_STOP : S_FETCH;
                    end
                end else if (trig) begin
                    st_r <= S_STOP;
                end else if (MOVE_DONE) begin
                    st_r <= (MOVE_KIND == `OP_END) ? S_DONE : S_FETCH;
                end
                if (trig) begin
                    testing_r <= 1'b0;
                    pc_r <= jdst_r[`ADDR_W-1:0] + 10'h001;
                    after_stop_r <= jdst_r[`ADDR_W-1:0];
                end
            end
            S_STOP: begin
                // first cycle only reads the move after the destination
                if (pc_r == after_stop_r) begin
                // continuous move keeps going only if allowed
                if (!pos_move_r && MOVE_KIND == `OP_CONTINUOUS_MOVE &&
                    (word[`OP_LSB+`OP_W-1:`OP_LSB] == `OP_CONTINUOUS_MOVE ||
                     word[`OP_LSB+`OP_W-1:`OP_LSB] == `OP_POSITIONING_MOVE) &&
                    word[`DIR_BIT] == dir_r &&
                    word[`DIST_W-1:0] > STOP_DIST) begin
                    CONT_JUMP <= 1'b1;
                    st_r <= S_FETCH;
                end else begin
                    // jog accel for the jump stop
                    JUMP_STOP <= 1'b1;
                    JOG_ACCEL_SEL <= 1'b1;
                    MOVE_ABORT <= 1'b1;
                    st_r <= S_WAITB;
                end
                end
                pc_r <= after_stop_r;
            end
            S_DONE: begin
                testing_r <= 1'b0;
                pend_r <= 1'b0;
                BUSY <= 1'b0;
                if (!RUN) begin
                    st_r <= S_IDLE;
                end
            end
            default: st_r <= S_IDLE;
            endcase
            if (st_r == S_WAITB && MOVE_DONE && JUMP_STOP) begin
                st_r <= S_FETCH;
            end
        end
    end

    // selected bit of a wait command
    function arg_bit;
        input [`ARG_W-1:0] a;
        begin
            arg_bit = (a[3:0] < `NUM_CTL) ? ctl_s[a[3:0]] : 1'b0;
        end
    endfunction
endmodule // motion_program_jump_sequencer

// *** inc/seq_consts.vh ***
// Purpose: constants for the motion program jump sequencer
// Assumes: 20 MHz clock, 2 ms jump test period
// Notes:   opcodes are a local encoding of stored program words
`ifndef SEQ_CONSTS_VH
`define SEQ_CONSTS_VH
`define CLK_HZ          20000000
`define TEST_PERIOD_US  2000
`define TEST_CYCLES     ((`CLK_HZ / 1000000) * `TEST_PERIOD_US)
`define TEST_CNT_W      16
`define NUM_CTL         12
`define NUM_SUBS        40
`define NUM_PROGS       10
`define NUM_AXES        2
`define ADDR_W          10
`define WORD_W          32
`define STACK_DEPTH     8
`define STACK_PTR_W     4
`define OP_LSB          28
`define OP_W            4
`define ARG_LSB         0
`define ARG_W           24
`define CTL_LSB         24
`define CTL_W           4
`define OP_NULL         4'h0
`define OP_POSITIONING_MOVE        4'h1
`define OP_CONTINUOUS_MOVE        4'h2
`define OP_DWELL        4'h3
`define OP_WAIT         4'h4
`define OP_END          4'h5
`define OP_BLOCK        4'h6
`define OP_JUMP         4'h7
`define OP_CJUMP        4'h8
`define OP_CALL         4'h9
`define OP_ENDSUB       4'ha
`define MULTI_BIT       23
`define DIR_BIT         22
`define DIST_W          22
`endif

// *** rtl/sync2.v ***
// Purpose: two flip-flop synchroniser for a vector of pin levels
// Assumes: input is asynchronous to clk
// Notes:   first stage read only by the second
`timescale 1ns/100ps
module sync2 #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // sync2

// *** rtl/prog_mem.v ***
// Purpose: stored program and subroutine memory
// Assumes: single write port, registered read
// Notes:   one cycle read latency
`timescale 1ns/100ps
`include "seq_consts.vh"
module prog_mem (
    input  wire                 clk,
    input  wire                 we,
    input  wire [`ADDR_W-1:0]   waddr,
    input  wire [`WORD_W-1:0]   wdata,
    input  wire [`ADDR_W-1:0]   raddr,
    output reg  [`WORD_W-1:0]   rdata
);
    reg [`WORD_W-1:0] mem [0:(1<<`ADDR_W)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // prog_mem

// *** bench/motion_program_jump_sequencer_chk.sv ***
// Purpose: port assertions for the jump sequencer
// Assumes: one clock domain, async active-low reset
// Notes:   bound below to every sequencer instance
`timescale 1ns/100ps
`include "seq_consts.vh"
module seq_chk (
    input wire              CLK,
    input wire              RESETN,
    input wire              MOVE_DONE,
    input wire              MOVE_START,
    input wire [`OP_W-1:0]  MOVE_KIND,
    input wire [`ARG_W-1:0] MOVE_ARG,
    input wire              JUMP_STOP,
    input wire              JOG_ACCEL_SEL,
    input wire              CONT_JUMP,
    input wire              MOVE_ABORT,
    input wire              BUSY,
    input wire              FAULT
);
    wire            is_move;
    reg             pend_r;
    reg [`OP_W-1:0] kind_r;
    assign is_move = MOVE_KIND == `OP_POSITIONING_MOVE || MOVE_KIND == `OP_CONTINUOUS_MOVE;
    // outstanding move, so an overlap shows
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pend_r <= 1'b0;
            kind_r <= `OP_NULL;
        end else if (MOVE_START && is_move) begin
            pend_r <= 1'b1;
            kind_r <= MOVE_KIND;
        end else if (MOVE_DONE || CONT_JUMP || MOVE_ABORT) begin
            pend_r <= 1'b0;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    AST_START_PULSE: assert property (MOVE_START |=> !MOVE_START)
        else $error("move start wider than one cycle");
    AST_MOVE_ORDER: assert property (MOVE_START && is_move && !CONT_JUMP |-> !pend_r)
        else $error("move started before previous one finished");
    AST_JOG_ON_STOP: assert property (JUMP_STOP |-> JOG_ACCEL_SEL)
        else $error("jump stop without jog acceleration");
    AST_STOP_OR_GO: assert property (CONT_JUMP |-> !JUMP_STOP [*3])
        else $error("jump both continued and stopped");
    AST_POSITIONING_MOVE_STOPS: assert property (CONT_JUMP |-> kind_r == `OP_CONTINUOUS_MOVE)
        else $error("jump without stop from a non-continuous move");
    AST_FAULT_HALT: assert property (FAULT |-> !MOVE_START && !CONT_JUMP)
        else $error("motion issued while faulted");
    AST_KIND_HOLD: assert property (!MOVE_START |-> $stable(MOVE_KIND) && $stable(MOVE_ARG))
        else $error("move command changed without a start");
    AST_START_BUSY: assert property (MOVE_START |-> BUSY)
        else $error("move start while idle");
endmodule // seq_chk

bind motion_program_jump_sequencer seq_chk u_chk (
    .CLK(CLK), .RESETN(RESETN), .MOVE_DONE(MOVE_DONE),
    .MOVE_START(MOVE_START), .MOVE_KIND(MOVE_KIND), .MOVE_ARG(MOVE_ARG),
    .JUMP_STOP(JUMP_STOP), .JOG_ACCEL_SEL(JOG_ACCEL_SEL),
    .CONT_JUMP(CONT_JUMP), .MOVE_ABORT(MOVE_ABORT), .BUSY(BUSY),
    .FAULT(FAULT));

// *** bench/move_gen_model.sv ***
// Purpose: behavioural move generator facing the sequencer
// Assumes: sequencer pulses move_start once per command
// Notes:   slow mode stretches one move past a test period
`timescale 1ns/100ps
module move_gen_model (
    input  wire clk,
    input  wire rst_n,
    input  wire move_start,
    input  wire jump_stop,
    input  wire cont_jump,
    input  wire move_abort,
    input  wire slow,
    output reg  move_done
);
    reg        busy_r;
    reg [16:0] cnt_r;
    // one axis, no sync blocks
    // a jump stop cuts the move short, as the servo would
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r    <= 1'b0;
            cnt_r     <= 17'h0;
            move_done <= 1'b0;
        end else begin
            move_done <= 1'b0;
            if (move_start) begin
                busy_r <= 1'b1;
                cnt_r  <= slow ? 17'h9ca4 : 17'h4 + 17'($urandom % 8);
            end else if (cont_jump) begin
                busy_r <= 1'b0;
            end else if (busy_r && (jump_stop || move_abort) &&
                         cnt_r > 17'h3) begin
                cnt_r <= 17'h3;
            end else if (busy_r && cnt_r == 17'h0) begin
                busy_r    <= 1'b0;
                move_done <= 1'b1;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 17'h1;
            end
        end
    end
endmodule // move_gen_model

// *** bench/motion_program_jump_sequencer_tb.sv ***
// Purpose: self-checking bench for the jump sequencer
// Assumes: 20 MHz clock, move generator model on the far side
// Notes:   the two jump runs each last one full test period
`timescale 1ns/100ps
`include "seq_consts.vh"
module motion_program_jump_sequencer_tb;
    reg                clk, resetn, multiaxis, run, load_we, sub_we;
    reg                sub_multi, slow;
    reg [`ADDR_W-1:0]  start_addr, load_addr, sub_addr;
    reg [`NUM_CTL-1:0] bits;
    reg [`WORD_W-1:0]  load_data;
    reg [5:0]          sub_num;
    reg [`DIST_W-1:0]  stop_dist;
    wire               move_done, move_start, jump_stop, jog_sel;
    wire               cont_jump, move_abort, busy, fault;
    wire [`OP_W-1:0]   move_kind;
    wire [`ARG_W-1:0]  move_arg;
    wire [15:0]        block_status;
    reg [`ARG_W-1:0]   got[$], exp_q[$];
    reg [`WORD_W-1:0]  img[$];
    reg [21:0]         dd[0:9];
    reg [5:0]          bad[0:3];
    integer            error_cnt, check_count, cycles, stops, conts;
    integer            i, j, k, t0, ka, kb, kc, blk;

    motion_program_jump_sequencer uut (
        .CLK(clk), .RESETN(resetn), .MULTIAXIS(multiaxis), .RUN(run),
        .START_ADDR(start_addr), .CONTROL_INPUT_BIT(bits),
        .LOAD_WE(load_we), .LOAD_ADDR(load_addr), .LOAD_DATA(load_data),
        .SUB_WE(sub_we), .SUB_NUM(sub_num), .SUB_ADDR(sub_addr),
        .SUB_MULTI(sub_multi), .STOP_DIST(stop_dist), .MOVE_DONE(move_done),
        .MOVE_START(move_start), .MOVE_KIND(move_kind), .MOVE_ARG(move_arg),
        .JUMP_STOP(jump_stop), .JOG_ACCEL_SEL(jog_sel),
        .CONT_JUMP(cont_jump), .MOVE_ABORT(move_abort),
        .BLOCK_STATUS(block_status), .BUSY(busy), .FAULT(fault));
    move_gen_model u_mg (
        .clk(clk), .rst_n(resetn), .move_start(move_start),
        .jump_stop(jump_stop), .cont_jump(cont_jump),
        .move_abort(move_abort), .slow(slow), .move_done(move_done));

    always #25 clk = ~clk;
    // log of moves issued, jump outcomes and a hang guard
    always @(posedge clk) begin
        if (move_start && (move_kind == `OP_POSITIONING_MOVE || move_kind == `OP_CONTINUOUS_MOVE))
            got.push_back(move_arg);
        if (jump_stop) stops = stops + 1;
        if (cont_jump) conts = conts + 1;
        cycles = cycles + 1;
        if (cycles == 98000) begin
            error_cnt = error_cnt + 1;
            report_and_stop;
        end
    end

    function [`WORD_W-1:0] w(input [3:0] op, input [3:0] c, input [23:0] a);
        w = {op, c, a};
    endfunction
    task cmp(input [31:0] got_v, input [31:0] exp_v);
        begin
            check_count = check_count + 1;
            if (got_v !== exp_v) begin
                error_cnt = error_cnt + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
            end
        end
    endtask
    task cmp_moves;
        begin
            cmp(got.size(), exp_q.size());
            for (i = 0; i < exp_q.size() && i < got.size(); i = i + 1)
                cmp(got[i], exp_q[i]);
        end
    endtask
    task put(input [`ADDR_W-1:0] a, input [`WORD_W-1:0] d);
        begin
            load_we <= 1'b1;
            load_addr <= a;
            load_data <= d;
            @(posedge clk);
        end
    endtask
    task prog(input [`ADDR_W-1:0] a);
        begin
            for (j = 0; j < img.size(); j = j + 1)
                put(a + j[`ADDR_W-1:0], img[j]);
            img.delete();
        end
    endtask
    task ent(input [5:0] n, input [`ADDR_W-1:0] a, input m);
        begin
            sub_we <= 1'b1;
            sub_num <= n;
            sub_addr <= a;
            sub_multi <= m;
            @(posedge clk);
        end
    endtask
    task do_reset;
        begin
            resetn <= 1'b0;
            repeat (10) @(posedge clk);
            resetn <= 1'b1;
            @(posedge clk);
        end
    endtask
    // programs and subroutine table; reloaded after each reset
    task setup;
        begin
            img = '{w(`OP_BLOCK, 0, blk), w(`OP_CONTINUOUS_MOVE, 0, dd[0]),
                w(`OP_WAIT, 0, ka), w(`OP_POSITIONING_MOVE, 0, dd[1]), w(`OP_WAIT, 0, kb),
                w(`OP_POSITIONING_MOVE, 0, dd[2]), w(`OP_END, 0, 0)};
            prog(10'h000);
            img = '{w(`OP_CALL, 0, 40), w(`OP_POSITIONING_MOVE, 0, dd[3]), w(`OP_END, 0, 0),
                w(`OP_POSITIONING_MOVE, 0, dd[4]), w(`OP_CALL, 0, 7), w(`OP_ENDSUB, 0, 0)};
            prog(10'h040);
            img = '{w(`OP_POSITIONING_MOVE, 0, dd[5]), w(`OP_ENDSUB, 0, 0),
                w(`OP_POSITIONING_MOVE, 0, dd[6]), w(`OP_ENDSUB, 0, 0),
                w(`OP_CALL, 0, 8), w(`OP_ENDSUB, 0, 0)};
            prog(10'h060);
            img = '{w(`OP_BLOCK, 0, 1), w(`OP_CJUMP, ka, 'h107),
                w(`OP_CJUMP, kb, 'h104),
                w(`OP_CONTINUOUS_MOVE, 0, dd[0]), w(`OP_BLOCK, 0, 2), w(`OP_CONTINUOUS_MOVE, 0, dd[1]),
                w(`OP_JUMP, 0, 'h109), w(`OP_BLOCK, 0, 3), w(`OP_POSITIONING_MOVE, 0, dd[2]),
                w(`OP_BLOCK, 0, 4), w(`OP_POSITIONING_MOVE, 0, dd[3]), w(`OP_END, 0, 0)};
            prog(10'h100);
            img = '{w(`OP_BLOCK, 0, 1), w(`OP_CJUMP, kc, 'h185),
                w(`OP_POSITIONING_MOVE, 0, dd[7]),
                w(`OP_BLOCK, 0, 2), w(`OP_POSITIONING_MOVE, 0, dd[8]), w(`OP_BLOCK, 0, 3),
                w(`OP_CONTINUOUS_MOVE, 0, dd[9]), w(`OP_END, 0, 0)};
            prog(10'h180);
            ent(6'h28, 10'h043, 1'b0);
            ent(6'h07, 10'h060, 1'b0);
            ent(6'h09, 10'h062, 1'b1);
            ent(6'h08, 10'h064, 1'b0);
            load_we <= 1'b0;
            sub_we <= 1'b0;
            @(posedge clk);
        end
    endtask
    task start(input [`ADDR_W-1:0] a);
        begin
            got.delete();
            exp_q.delete();
            stops = 0;
            conts = 0;
            start_addr <= a;
            run <= 1'b1;
            @(posedge clk);
        end
    endtask
    // waits for quiet after n moves, or a fault
    task finish(input integer n);
        begin
            k = 0;
            while (k < 300 && fault !== 1'b1) begin
                @(posedge clk);
                if (move_start || move_done || got.size() < n) k = 0;
                else k = k + 1;
            end
            run <= 1'b0;
            repeat (5) @(posedge clk);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks=%0d errors=%0d", check_count, error_cnt);
            if (error_cnt == 0 && check_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    initial begin
        {clk, resetn, multiaxis, run, load_we, sub_we, sub_multi, slow} = 8'h0;
        {start_addr, load_addr, sub_addr, load_data, sub_num} = 0;
        bits = 0;
        stop_dist = 0;
        {error_cnt, check_count, cycles, stops, conts} = 0;
        bad = '{6'h29, 6'h00, 6'h09, 6'h08};
        k = $urandom(32'hf160);
        for (i = 0; i < 10; i = i + 1) dd[i] = 1000 + $urandom % 60000;
        ka = $urandom % 12;
        kb = (ka + 1 + $urandom % 11) % 12;
        kc = $urandom % 12;
        blk = 1 + $urandom % 200;
        do_reset;
        setup;
        cmp({move_start, jump_stop, cont_jump, busy, fault, block_status}, 0);
        // wait on an unset bit holds, a set one passes straight on
        bits <= 12'h001 << kb;
        stop_dist <= $urandom;
        start(10'h000);
        while (got.size() < 1) @(posedge clk);
        repeat (300) @(posedge clk);
        cmp(got.size(), 1);
        cmp(block_status, blk);
        bits <= bits | (12'h001 << ka);
        finish(3);
        exp_q = '{dd[0], dd[1], dd[2]};
        cmp_moves;
        // nested calls return in order
        start(10'h040);
        finish(3);
        exp_q = '{dd[4], dd[5], dd[3]};
        cmp_moves;
        cmp(fault, 0);
        // out of range, number zero, wrong scope, recursion
        for (t0 = 0; t0 < 4; t0 = t0 + 1) begin
            do_reset;
            setup;
            put(10'h080, w(`OP_CALL, 0, bad[t0]));
            load_we <= 1'b0;
            start(10'h080);
            finish(0);
            cmp(fault, 1);
            cmp(got.size(), 0);
        end
        do_reset;
        setup;
        // earlier jump with bit on is dropped; plain jump skips block 3
        bits <= 12'h001 << ka;
        start(10'h100);
        finish(3);
        exp_q = '{dd[0], dd[1], dd[3]};
        cmp_moves;
        cmp(stops + conts, 0);
        // jump taken mid-move: stop from one kind, run on from the other
        for (t0 = 0; t0 < 2; t0 = t0 + 1) begin
            put(10'h182, w(t0 ? `OP_CONTINUOUS_MOVE : `OP_POSITIONING_MOVE, 0, dd[7]));
            load_we <= 1'b0;
            bits <= 0;
            stop_dist <= dd[9] >> 1;
            slow <= 1'b1;
            start(10'h180);
            while (got.size() < 1) @(posedge clk);
            k = cycles;
            slow <= 1'b0;
            repeat (10) @(posedge clk);
            bits <= 12'h001 << kc;
            while (stops + conts == 0) @(posedge clk);
            cmp(cycles - k >= 39980 && cycles - k <= 40030, 1);
            cmp(stops > 0, t0 == 0);
            cmp(conts > 0, t0 == 1);
            finish(2);
            exp_q = '{dd[7], dd[9]};
            cmp_moves;
            cmp(block_status, 3);
        end
        report_and_stop;
    end
endmodule // motion_program_jump_sequencer_tb
